//--- rail_voltage_status_register_test.sv
/*
 * self-checking testbench for the rail voltage status register.
 * assumes the host model drives commands; comparators driven here at negedge.
 */
`timescale 1ns/1ps

module rail_voltage_status_register_test;
    import rvs_pkg::*;

    logic                      mclk;
    logic                      rstn;
    logic                      ce;
    logic                      xen;
    logic                      got;
    logic                      cmd_valid;
    logic                      cmd_write;
    logic [RVS_CMD_WIDTH-1:0]  cmd_code;
    logic                      rsp_valid;
    rvs_flags_type             rsp_data;
    rvs_flags_type             live;
    rvs_flags_type             cmp;
    rvs_flags_type             seen;
    int                        error_cnt;
    int                        checked;

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    rvs_top u_dut (
        .mclk                  (mclk),
        .rstn                  (rstn),
        .ce                    (ce),
        .prereg_ov_cmp         (cmp[PREREG_OV_BIT]),
        .prereg_uv_cmp         (cmp[PREREG_UV_BIT]),
        .xcvr_rail_ov_cmp      (cmp[XCVR_OV_BIT]),
        .xcvr_rail_uv_cmp      (cmp[XCVR_UV_BIT]),
        .io_rail_ov_cmp        (cmp[IO_OV_BIT]),
        .io_rail_uv_cmp        (cmp[IO_UV_BIT]),
        .core_rail_ov_cmp      (cmp[CORE_OV_BIT]),
        .core_rail_uv_cmp      (cmp[CORE_UV_BIT]),
        .xcvr_regulator_enable (xen),
        .cmd_valid             (cmd_valid),
        .cmd_write             (cmd_write),
        .cmd_code              (cmd_code),
        .rsp_valid             (rsp_valid),
        .rsp_data              (rsp_data),
        .rail_voltage_status   (live)
    );

    rvs_host_model u_host (
        .mclk      (mclk),
        .cmd_valid (cmd_valid),
        .cmd_write (cmd_write),
        .cmd_code  (cmd_code),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data)
    );

    task automatic check(input string name, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // drive comparators, wait out the three-edge latency
    task automatic settle(input rvs_flags_type v);
        @(negedge mclk);
        cmp = v;
        repeat (3) @(negedge mclk);
    endtask

    // dedicated read, answer and following idle cycle judged
    task automatic read_expect(input rvs_flags_type e);
        u_host.send(1'b0, RVS_READ_CMD_DEF, got, seen);
        check("rsp_valid", {7'h00, got}, 8'h01);
        check("rsp_data", seen, e);
        @(negedge mclk);
        check("rsp_idle", {7'h00, rsp_valid}, 8'h00);
    endtask

    task automatic t_reset;
        check("live_reset", live, RVS_RESET);
        read_expect(8'h00);
    endtask

    // each field alone, then all, each clearing by itself
    task automatic t_fields;
        for (int i = 0; i < 8; i++)
        begin
            settle(8'h01 << i);
            check("live_field", live, 8'h01 << i);
            read_expect(8'h01 << i);
            settle(8'h00);
            check("live_clear", live, 8'h00);
        end
        settle(8'hff);
        check("live_all", live, 8'hff);
        settle(8'h00);
        check("live_none", live, 8'h00);
    endtask

    // regulator disabled: undervoltage still reported
    task automatic t_disabled;
        @(negedge mclk);
        xen = 1'b0;
        settle(8'h01 << XCVR_UV_BIT);
        check("xcvr_uv_off", live, 8'h10);
        read_expect(8'h10);
        settle(8'h00);
        check("xcvr_uv_gone", live, 8'h00);
        xen = 1'b1;
    endtask

    // writes and foreign codes refused, flags untouched
    task automatic t_refused;
        settle(8'h5a);
        u_host.send(1'b1, RVS_READ_CMD_DEF, got, seen);
        check("write_ignored", {7'h00, got}, 8'h00);
        u_host.send(1'b0, ~RVS_READ_CMD_DEF, got, seen);
        check("code_ignored", {7'h00, got}, 8'h00);
        check("live_kept", live, 8'h5a);
        read_expect(8'h5a);
        read_expect(8'h5a);
        check("live_after_read", live, 8'h5a);
    endtask

    // clock enable low freezes the flags
    task automatic t_ce;
        @(negedge mclk);
        ce  = 1'b0;
        cmp = 8'h81;
        repeat (4) @(negedge mclk);
        check("ce_frozen", live, 8'h5a);
        ce = 1'b1;
        repeat (3) @(negedge mclk);
        check("ce_resumed", live, 8'h81);
    endtask

    // reset in mid-run clears flags and answer, flags return after release
    task automatic t_reset_mid;
        @(negedge mclk);
        rstn = 1'b0;
        @(negedge mclk);
        check("mid_reset_live", live, RVS_RESET);
        check("mid_reset_rsp", rsp_data, RVS_RESET);
        rstn = 1'b1;
        @(negedge mclk);
        check("mid_release_live", live, RVS_RESET);
        repeat (2) @(negedge mclk);
        check("mid_resumed", live, 8'h81);
    endtask

    // watchdog
    initial
    begin
        #20000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        error_cnt = 0;
        checked   = 0;
        rstn      = 1'b0;
        ce        = 1'b1;
        xen       = 1'b1;
        cmp       = 8'h00;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_fields();
        t_disabled();
        t_refused();
        t_ce();
        t_reset_mid();
        complete_run();
    end
endmodule

//--- rvs_flags_if.sv
/*
 * carries the synchronised comparator flags from the input stage to the core.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface rvs_flags_if;
    import rvs_pkg::*;

    rvs_flags_type flags;

    // input stage drives, core reads
    modport sync_mp (output flags);
    modport core_mp (input flags);
endinterface

//--- rvs_host_model.sv
/*
 * host controller model: issues serial commands to the rail status register
 * and captures the answer at the falling edge after the taking edge.
 * assumes inputs change only at the rising edge of mclk.
 */
`timescale 1ns/1ps

module rvs_host_model
    import rvs_pkg::*;
(
    // clock
    input  wire logic                     mclk,
    // command side
    output logic                          cmd_valid,
    output logic                          cmd_write,
    output logic [RVS_CMD_WIDTH-1:0]      cmd_code,
    // answer side
    input  wire logic                     rsp_valid,
    input  wire rvs_flags_type            rsp_data
);
    // idle until the first command
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b1;
        cmd_code  = 8'h00;
    end

    // one-cycle command pulse, answer sampled one cycle later
    task automatic send(input logic wr, input logic [RVS_CMD_WIDTH-1:0] code,
                        output logic got, output rvs_flags_type data);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_write = ~wr;   // released lines show no stale value
        cmd_code  = ~code;
        got       = rsp_valid;
        data      = rsp_data;
    endtask
endmodule

//--- rvs_pkg.sv
/*
 * rail voltage status: shared constants, field positions and types.
 * assumes nothing of its surroundings; imported whole by every module.
 */
package rvs_pkg;

    // register width and reset value
    localparam int unsigned RVS_WIDTH = 8;
    localparam logic [7:0]  RVS_RESET = 8'h00;

    // field positions, bit 7 down to bit 0
    localparam int unsigned PREREG_OV_BIT = 7;
    localparam int unsigned PREREG_UV_BIT = 6;
    localparam int unsigned XCVR_OV_BIT   = 5;
    localparam int unsigned XCVR_UV_BIT   = 4;
    localparam int unsigned IO_OV_BIT     = 3;
    localparam int unsigned IO_UV_BIT     = 2;
    localparam int unsigned CORE_OV_BIT   = 1;
    localparam int unsigned CORE_UV_BIT   = 0;

    // groups of fields
    localparam logic [7:0] RVS_OV_MASK = 8'haa;
    localparam logic [7:0] RVS_UV_MASK = 8'h55;

    // serial command port
    localparam int unsigned RVS_CMD_WIDTH    = 8;
    // read command code: value is arbitrary, set per system
    localparam logic [7:0]  RVS_READ_CMD_DEF = 8'h2a;

    // comparator to flag latency in clock cycles
    localparam logic [1:0]  RVS_PIPE_DEPTH = 2'h3;

    typedef logic [RVS_WIDTH-1:0] rvs_flags_type;

endpackage

//--- rvs_sync.sv
/*
 * two-stage synchroniser for the analog comparator outputs.
 * assumes the raw inputs are asynchronous to mclk; rstn is synchronous.
 */
`timescale 1ns/1ps

module rvs_sync
    import rvs_pkg::*;
(
    // clock, reset, enable
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          ce,
    // raw comparator levels
    input  wire rvs_flags_type raw_in,
    // synchronised levels
    rvs_flags_if.sync_mp       sync_port
);

    rvs_flags_type meta_reg;
    rvs_flags_type meta_next;
    rvs_flags_type sync_reg;
    rvs_flags_type sync_next;

    // next values: first stage feeds only the second
    always_comb
    begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (ce)
        begin
            meta_next = raw_in;
            sync_next = meta_reg;
        end
    end

    // registers, cleared by reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            meta_reg <= RVS_RESET;
            sync_reg <= RVS_RESET;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_port.flags = sync_reg;

endmodule

//--- rvs_top.sv
/*
 * rail voltage status register: live over/undervoltage flags of four rails,
 * read by a dedicated serial read command.
 * assumes the comparator outputs are asynchronous levels and that a serial
 * front end delivers decoded commands on mclk.
 */
// Function
// - core undervoltage sets bit zero
// - core overvoltage sets bit one
// - transceiver overvoltage sets bit five
// - overvoltage flags clear when fault gone
// - undervoltage flags clear when fault gone
// - transceiver undervoltage reported despite regulator disabled
// - disabled discharged transceiver rail sets undervoltage
// - fixed field order, one bit each
// - reset clears flags; read command returns register
`timescale 1ns/1ps

module rvs_top
    import rvs_pkg::*;
#(
    parameter int unsigned                 CMD_WIDTH     = RVS_CMD_WIDTH,
    parameter logic [RVS_CMD_WIDTH-1:0]    READ_CMD_CODE = RVS_READ_CMD_DEF
)
(
    // clock, reset, enable
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    // comparator outputs, high while the fault is present
    input  wire logic                      prereg_ov_cmp,
    input  wire logic                      prereg_uv_cmp,
    input  wire logic                      xcvr_rail_ov_cmp,
    input  wire logic                      xcvr_rail_uv_cmp,
    input  wire logic                      io_rail_ov_cmp,
    input  wire logic                      io_rail_uv_cmp,
    input  wire logic                      core_rail_ov_cmp,
    input  wire logic                      core_rail_uv_cmp,
    // regulator enable from the sensor control register
    input  wire logic                      xcvr_regulator_enable,
    // decoded serial command
    input  wire logic                      cmd_valid,
    input  wire logic                      cmd_write,
    input  wire logic [RVS_CMD_WIDTH-1:0]  cmd_code,
    // read answer
    output logic                           rsp_valid,
    output rvs_flags_type                  rsp_data,
    // live register contents
    output rvs_flags_type                  rail_voltage_status
);

    // refuse a command width the decoder cannot serve
    if (CMD_WIDTH != RVS_CMD_WIDTH)
    begin : g_bad_width
        $error("rvs_top: CMD_WIDTH must equal the command code width");
    end

    // places each comparator at its field position
    function automatic rvs_flags_type pack_flags(
        input logic p_ov,
        input logic p_uv,
        input logic x_ov,
        input logic x_uv,
        input logic i_ov,
        input logic i_uv,
        input logic c_ov,
        input logic c_uv
    );
        rvs_flags_type v;
        v                = RVS_RESET;
        v[PREREG_OV_BIT] = p_ov;
        v[PREREG_UV_BIT] = p_uv;
        v[XCVR_OV_BIT]   = x_ov;
        v[XCVR_UV_BIT]   = x_uv;
        v[IO_OV_BIT]     = i_ov;
        v[IO_UV_BIT]     = i_uv;
        v[CORE_OV_BIT]   = c_ov;
        v[CORE_UV_BIT]   = c_uv;
        return v;
    endfunction

    rvs_flags_type raw_vec;
    rvs_flags_type flags_reg;
    rvs_flags_type flags_next;
    logic          rsp_valid_reg;
    logic          rsp_valid_next;
    rvs_flags_type rsp_data_reg;
    rvs_flags_type rsp_data_next;
    logic          read_hit;

    rvs_flags_if   flags_bus ();

    // comparators packed into register order
    assign raw_vec = pack_flags(prereg_ov_cmp, prereg_uv_cmp,
                                xcvr_rail_ov_cmp, xcvr_rail_uv_cmp,
                                io_rail_ov_cmp, io_rail_uv_cmp,
                                core_rail_ov_cmp, core_rail_uv_cmp);

    // comparator levels cross into mclk
    rvs_sync u_sync (
        .mclk      (mclk),
        .rstn      (rstn),
        .ce        (ce),
        .raw_in    (raw_vec),
        .sync_port (flags_bus.sync_mp)
    );

    // read command decode; writes never answer
    assign read_hit = cmd_valid && !cmd_write && (cmd_code == READ_CMD_CODE);

    // next values: flags mirror comparators, reads only copy them
    always_comb
    begin
        flags_next     = flags_reg;
        rsp_valid_next = rsp_valid_reg;
        rsp_data_next  = rsp_data_reg;
        if (ce)
        begin
            // live flags, set and cleared by the comparator alone
            flags_next     = flags_bus.flags;
            // regulator enable does not gate the undervoltage flag
            flags_next[XCVR_UV_BIT] = flags_bus.flags[XCVR_UV_BIT];
            rsp_valid_next = read_hit;
            if (read_hit)
            begin
                rsp_data_next = flags_reg;
            end
        end
    end

    // registers, all flags zero after reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            flags_reg     <= RVS_RESET;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= RVS_RESET;
        end
        else
        begin
            flags_reg     <= flags_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg  <= rsp_data_next;
        end
    end

    // outputs straight from flip-flops
    assign rsp_valid           = rsp_valid_reg;
    assign rsp_data            = rsp_data_reg;
    assign rail_voltage_status = flags_reg;

    // helper: counts consecutive running cycles, saturating at pipe depth
    logic [1:0] run_cnt_reg;
    logic [1:0] run_cnt_next;
    logic       run_ok;

    // next count: restarts while stalled, stops at pipe depth
    always_comb
    begin
        run_cnt_next = run_cnt_reg;
        if (!ce)
        begin
            run_cnt_next = 2'h0;
        end
        else if (run_cnt_reg != RVS_PIPE_DEPTH)
        begin
            run_cnt_next = run_cnt_reg + 2'h1;
        end
    end

    // count register, cleared by reset
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            run_cnt_reg <= 2'h0;
        end
        else
        begin
            run_cnt_reg <= run_cnt_next;
        end
    end

    assign run_ok = (run_cnt_reg == RVS_PIPE_DEPTH);

    // core undervoltage reaches bit zero three cycles on
    a_core_uv_flag: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok |-> (flags_reg[CORE_UV_BIT] == $past(core_rail_uv_cmp, 3)))
        else $error("core undervoltage flag does not follow its comparator");

    // core overvoltage reaches bit one three cycles on
    a_core_ov_flag: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok && $past(core_rail_ov_cmp, 3) |-> flags_reg[CORE_OV_BIT])
        else $error("core overvoltage flag not set");

    // transceiver overvoltage reaches bit five
    a_xcvr_ov_flag: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok && $past(xcvr_rail_ov_cmp, 3) |-> flags_reg[XCVR_OV_BIT])
        else $error("transceiver overvoltage flag not set");

    // overvoltage flags fall with their comparators
    a_ov_live_clear: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok |-> ((flags_reg & RVS_OV_MASK) == ($past(raw_vec, 3) & RVS_OV_MASK)))
        else $error("overvoltage flags are not live");

    // undervoltage flags fall with their comparators
    a_uv_live_clear: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok |-> ((flags_reg & RVS_UV_MASK) == ($past(raw_vec, 3) & RVS_UV_MASK)))
        else $error("undervoltage flag stuck after fault gone");

    // transceiver undervoltage reported while regulator disabled
    a_xcvr_uv_disabled: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok && !$past(xcvr_regulator_enable, 3) |->
            (flags_reg[XCVR_UV_BIT] == $past(xcvr_rail_uv_cmp, 3)))
        else $error("transceiver undervoltage hidden by regulator disable");

    // discharge below threshold with regulator off sets the flag
    a_xcvr_uv_discharge: assert property (@(posedge mclk) disable iff (!rstn)
        !xcvr_regulator_enable && $rose(xcvr_rail_uv_cmp) && ce ##1 ce [*2] |=>
            flags_reg[XCVR_UV_BIT])
        else $error("discharged transceiver rail did not set undervoltage");

    // preregulator fields in the top two bits
    a_field_order: assert property (@(posedge mclk) disable iff (!rstn)
        run_ok |-> (flags_reg[PREREG_OV_BIT] == $past(prereg_ov_cmp, 3)) &&
                   (flags_reg[PREREG_UV_BIT] == $past(prereg_uv_cmp, 3)) &&
                   (flags_reg[IO_OV_BIT] == $past(io_rail_ov_cmp, 3)))
        else $error("flag field order wrong");

    // reset clears every flag and the answer
    a_reset_clear: assert property (@(posedge mclk)
        !rstn |=> (flags_reg == RVS_RESET) && !rsp_valid && (rsp_data == RVS_RESET))
        else $error("reset did not clear the register");

    // read command answered next cycle with the register value
    a_read_answer: assert property (@(posedge mclk) disable iff (!rstn)
        ce && read_hit |=> rsp_valid && (rsp_data == $past(rail_voltage_status)))
        else $error("read command not answered with register value");

    // write attempts give no answer
    a_write_ignored: assert property (@(posedge mclk) disable iff (!rstn)
        ce && cmd_valid && cmd_write |=> !rsp_valid)
        else $error("write to read-only status register answered");

endmodule
